// ---- pmt_consts.svh ----
// timing and framing constants for the second-pulse time message sender
// assumes a 25 MHz system clock; times in their own unit, counts derived
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
`define PMT_CLK_HZ        25000000
`define PMT_BAUD          9600
`define PMT_BIT_CYC       (`PMT_CLK_HZ / `PMT_BAUD)
`define PMT_START_MS      10
`define PMT_DEADLINE_MS   500
`define PMT_START_CYC     ((`PMT_START_MS * `PMT_CLK_HZ) / 1000)
`define PMT_DEADLINE_CYC  ((`PMT_DEADLINE_MS * `PMT_CLK_HZ) / 1000)
`define PMT_FRAME_BITS    10
`define PMT_DATA_BITS     8
`define PMT_MSG_BYTES     16
`define PMT_HDR_SYNC      8'hA5
`define PMT_MSG_TYPE      8'h01
`define PMT_MSG_ID        8'h01
`define PMT_DELAY_W       24
`endif

// ---- pmt_pkg.sv ----
// types for the second-pulse time message sender
// constants live in pmt_consts.svh
package pmt_pkg;
   typedef enum logic [1:0] {
      PMT_IDLE = 2'b00,
      PMT_WAIT = 2'b01,
      PMT_SEND = 2'b11
   } pmt_state_t;
endpackage

// ---- pmt_time_msg_tx.sv ----
// time message serial sender aligned to the second pulse
// assumes second_pulse and time_now are synchronous to clk
//
// What this block does
// - message starts a fixed delay after each second_pulse rising edge seen while idle
// - every message byte completes within 500 ms of its pulse edge
// - message carries time latched at the pulse edge, not at start
// - exactly one message per second pulse edge seen while idle; edges while busy are ignored
// - whole bytes, binary, closing checksum byte over contents
// - message holds a type byte and an identifier byte
// - multibyte fields go most significant byte first
// - bit 0 of each byte goes on the line first
// - 9600 baud, no parity
// - one low start bit per character
// - one high stop bit; line idles high
// - eight data bits per character
`timescale 1ns/10ps
`include "pmt_consts.svh"
module pmt_time_msg_tx #(
   parameter int unsigned START_CYC = `PMT_START_CYC,
   parameter int unsigned DEADLINE_CYC = `PMT_DEADLINE_CYC,
   parameter bit          CSUM_XOR = 1'b0,
   parameter logic [7:0]  MSG_TYPE = `PMT_MSG_TYPE,
   parameter logic [7:0]  MSG_ID = `PMT_MSG_ID
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // timing inputs
   input  wire logic        second_pulse,
   input  wire logic [95:0] time_now,
   // serial line and status
   output logic             txd,
   output logic             busy,
   output logic             late_err
);
   localparam int MSG_BYTES = `PMT_MSG_BYTES;
   localparam int BODY = MSG_BYTES - 1;
   localparam int unsigned MSG_CYC = MSG_BYTES * `PMT_FRAME_BITS
                                     * `PMT_BIT_CYC;

   // start delay plus full message must fit before the deadline
   initial begin
      if (START_CYC + MSG_CYC > DEADLINE_CYC) begin
         $error("start delay leaves no room before deadline");
      end
   end

   pmt_pkg::pmt_state_t state_ff, nxt_state;
   logic        pulse_d_ff, nxt_pulse_d;
   logic [95:0] stamp_ff, nxt_stamp;
   logic [24:0] wait_ff, nxt_wait;
   logic [24:0] age_ff, nxt_age;
   logic [11:0] baud_ff, nxt_baud;
   logic [3:0]  bit_ff, nxt_bit;
   logic [3:0]  byte_ff, nxt_byte;
   logic [9:0]  shift_ff, nxt_shift;
   logic [7:0]  csum_ff, nxt_csum;
   logic        txd_ff, nxt_txd;
   logic        busy_ff, nxt_busy;
   logic        late_ff, nxt_late;
   logic [7:0]  body_bytes [BODY];
   logic        pulse_rise;
   logic [7:0]  cur_byte;

   // fixed body: sync, type, id, then the time big-endian
   assign body_bytes[0] = `PMT_HDR_SYNC;
   assign body_bytes[1] = MSG_TYPE;
   assign body_bytes[2] = MSG_ID;
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_time
         assign body_bytes[gi+3] = stamp_ff[95-8*gi -: 8];
      end
   endgenerate

   assign pulse_rise = second_pulse & ~pulse_d_ff;
   // last byte is the checksum of all bytes before it
   assign cur_byte = (byte_ff == 4'(BODY)) ? csum_ff
                                            : body_bytes[byte_ff];

   // sequencing and serializer next state
   always_comb begin
      nxt_state   = state_ff;
      nxt_pulse_d = second_pulse;
      nxt_stamp   = stamp_ff;
      nxt_wait    = wait_ff;
      nxt_age     = (age_ff == '1) ? age_ff : age_ff + 25'd1;
      nxt_baud    = baud_ff;
      nxt_bit     = bit_ff;
      nxt_byte    = byte_ff;
      nxt_shift   = shift_ff;
      nxt_csum    = csum_ff;
      nxt_txd     = 1'b1;
      nxt_busy    = 1'b0;
      nxt_late    = late_ff;
      case (state_ff)
         pmt_pkg::PMT_IDLE: begin
            if (pulse_rise) begin
               nxt_stamp = time_now;
               nxt_wait  = 25'(START_CYC);
               nxt_age   = '0;
               nxt_busy  = 1'b1; // busy the cycle after the edge
               nxt_state = pmt_pkg::PMT_WAIT;
            end
         end
         pmt_pkg::PMT_WAIT: begin
            nxt_busy = 1'b1;
            if (wait_ff <= 25'd1) begin
               nxt_byte  = '0;
               nxt_bit   = '0;
               nxt_baud  = '0;
               nxt_csum  = '0;
               nxt_shift = {1'b1, `PMT_HDR_SYNC, 1'b0};
               nxt_state = pmt_pkg::PMT_SEND;
            end else begin
               nxt_wait = wait_ff - 25'd1;
            end
         end
         pmt_pkg::PMT_SEND: begin
            nxt_busy = 1'b1;
            nxt_txd  = shift_ff[0];
            if (age_ff >= 25'(DEADLINE_CYC)) begin
               nxt_late = 1'b1;
            end
            if (baud_ff == 12'(`PMT_BIT_CYC - 1)) begin
               nxt_baud = '0;
               if (bit_ff == 4'(`PMT_FRAME_BITS - 1)) begin
                  nxt_bit  = '0;
                  nxt_csum = CSUM_XOR ? (csum_ff ^ cur_byte)
                                      : 8'(csum_ff + cur_byte);
                  if (byte_ff == 4'(BODY)) begin
                     nxt_state = pmt_pkg::PMT_IDLE;
                  end else begin
                     nxt_byte  = byte_ff + 4'd1;
                     nxt_shift = {1'b1,
                        (byte_ff + 4'd1 == 4'(BODY)) ?
                           (CSUM_XOR ? (csum_ff ^ cur_byte)
                                     : 8'(csum_ff + cur_byte))
                         : body_bytes[byte_ff + 4'd1],
                        1'b0};
                  end
               end else begin
                  nxt_bit   = bit_ff + 4'd1;
                  nxt_shift = {1'b1, shift_ff[9:1]};
               end
            end else begin
               nxt_baud = baud_ff + 12'd1;
            end
         end
         default: nxt_state = pmt_pkg::PMT_IDLE;
      endcase
   end

   // register all state; line idles high out of reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_ff   <= pmt_pkg::PMT_IDLE;
         pulse_d_ff <= 1'b1; // no false edge if pulse is high at reset
         stamp_ff   <= '0;
         wait_ff    <= '0;
         age_ff     <= '0;
         baud_ff    <= '0;
         bit_ff     <= '0;
         byte_ff    <= '0;
         shift_ff   <= '1;
         csum_ff    <= '0;
         txd_ff     <= 1'b1;
         busy_ff    <= 1'b0;
         late_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         pulse_d_ff <= nxt_pulse_d;
         stamp_ff   <= nxt_stamp;
         wait_ff    <= nxt_wait;
         age_ff     <= nxt_age;
         baud_ff    <= nxt_baud;
         bit_ff     <= nxt_bit;
         byte_ff    <= nxt_byte;
         shift_ff   <= nxt_shift;
         csum_ff    <= nxt_csum;
         txd_ff     <= nxt_txd;
         busy_ff    <= nxt_busy;
         late_ff    <= nxt_late;
      end
   end

   assign txd      = txd_ff;
   assign busy     = busy_ff;
   assign late_err = late_ff;
endmodule

// ---- pmt_time_msg_tx_assertions.sv ----
// checker for the time message sender
// sees only top ports; bound below
`timescale 1ns/10ps
module pmt_tx_chk #(
   parameter int unsigned START_CYC = 250000,
   parameter int unsigned DEADLINE_CYC = 12500000
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        second_pulse,
   input wire logic [95:0] time_now,
   input wire logic        txd,
   input wire logic        busy,
   input wire logic        late_err
);
   localparam int D1 = START_CYC + 1;
   localparam int D2 = START_CYC + 3;
   logic        sp_ff;
   logic        st_ff;
   logic [11:0] ph_ff;
   logic [3:0]  bit_ff;
   wire         run = busy & (st_ff | !txd);
   wire         trig = second_pulse & !sp_ff & !busy;
   // cycles since an accepted edge, until the first start bit
   logic        go_ff;
   int          go_cnt_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // counter instead of a delay range: the real delay is far too long
   always_ff @(posedge clk) begin
      if (!rstn) begin
         go_ff     <= 1'b0;
         go_cnt_ff <= 0;
      end else if (trig) begin
         go_ff     <= 1'b1;
         go_cnt_ff <= 1;
      end else begin
         go_ff     <= go_ff & txd;
         go_cnt_ff <= go_cnt_ff + 1;
      end
   end
   // bit phase from the first start edge; chars run back to back
   always_ff @(posedge clk) begin
      sp_ff <= rstn ? second_pulse : 1'b1;
      st_ff <= run;
      ph_ff <= (!run || ph_ff == 12'd2603) ? 12'd0 : ph_ff + 12'd1;
      if (!run)
         bit_ff <= 4'd0;
      else if (ph_ff == 12'd2603)
         bit_ff <= (bit_ff == 4'd9) ? 4'd0 : bit_ff + 4'd1;
   end
   property p_busy; trig |=> busy; endproperty
   a_busy: assert property (p_busy) else $error("no busy");
   property p_wait; trig |=> txd [*8]; endproperty
   a_wait: assert property (p_wait) else $error("early");
   property p_go;
      go_ff |-> go_cnt_ff <= D2 && (txd || go_cnt_ff >= D1);
   endproperty
   a_go: assert property (p_go) else $error("start off time");
   property p_idle; !busy |-> txd; endproperty
   a_idle: assert property (p_idle) else $error("idle low");
   property p_late; busy |-> !late_err; endproperty
   a_late: assert property (p_late) else $error("late");
   property p_ph; busy && st_ff && $changed(txd) |-> ph_ff == 12'd0;
   endproperty
   a_ph: assert property (p_ph) else $error("bit width");
   property p_sb; st_ff && ph_ff == 12'd1302 && bit_ff == 4'd0 |-> !txd;
   endproperty
   a_sb: assert property (p_sb) else $error("start bit");
   property p_eb; st_ff && ph_ff == 12'd1302 && bit_ff == 4'd9 |-> txd;
   endproperty
   a_eb: assert property (p_eb) else $error("stop bit");
   c_trig: cover property (trig);
   c_end: cover property ($fell(busy));
   c_stop: cover property (st_ff && bit_ff == 4'd9);
endmodule
bind pmt_time_msg_tx pmt_tx_chk #(.START_CYC(START_CYC),
   .DEADLINE_CYC(DEADLINE_CYC)) chk (.clk(clk), .rstn(rstn),
   .second_pulse(second_pulse), .time_now(time_now), .txd(txd),
   .busy(busy), .late_err(late_err));

// ---- pmt_rx_model.sv ----
// serial receiver model of the far side
// samples each bit at its centre
`timescale 1ns/10ps
`include "pmt_consts.svh"
module pmt_rx_model (
   // clock and line
   input  wire logic clk,
   input  wire logic txd,
   // received character
   output logic [7:0] rx_byte,
   output logic       rx_ok,
   output logic       rx_valid
);
   localparam int BC = `PMT_BIT_CYC;
   logic ok_b;
   initial rx_valid = 1'b0;
   // one char per falling edge, no parity slot
   always begin
      @(negedge txd);
      repeat (BC / 2) @(posedge clk);
      ok_b = !txd;
      for (int i = 0; i < 8; i++) begin
         repeat (BC) @(posedge clk);
         rx_byte[i] <= txd;
      end
      repeat (BC) @(posedge clk);
      rx_ok <= ok_b & txd;
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
   end
endmodule

// ---- tb_top.sv ----
// bench: one full message, short start delay
// expects pmt_rx_model on the line
`timescale 1ns/10ps
`include "pmt_consts.svh"
module tb_top;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        second_pulse = 1'b0;
   logic [95:0] time_now = 96'h0;
   logic        txd, busy, late_err, rx_ok, rx_valid;
   logic [7:0]  rx_byte;
   logic [7:0]  exq [16];
   logic [95:0] stamp;
   logic [31:0] rnd = 32'h5315;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          nrx = 0;
   always #20 clk = ~clk;
   pmt_time_msg_tx #(.START_CYC(20), .DEADLINE_CYC(450000)) uut (
      .clk(clk), .rstn(rstn), .second_pulse(second_pulse),
      .time_now(time_now), .txd(txd), .busy(busy), .late_err(late_err));
   pmt_rx_model rx (.clk(clk), .txd(txd), .rx_byte(rx_byte),
      .rx_ok(rx_ok), .rx_valid(rx_valid));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int i = 0; i < 32; i++)
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard and character count
   always @(posedge clk) begin
      cyc <= cyc + 1;
      nrx <= nrx + int'(rx_valid === 1'b1);
      if (cyc == 440000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rnd = lfsr(rnd);
      stamp = {rnd, lfsr(rnd), 32'hFFFF0000}; // sum carries
      exq[0] = `PMT_HDR_SYNC;
      exq[1] = `PMT_MSG_TYPE;
      exq[2] = `PMT_MSG_ID;
      for (int i = 0; i < 12; i++)
         exq[3 + i] = stamp[95 - 8 * i -: 8];
      exq[15] = 8'h00;
      for (int i = 0; i < 15; i++)
         exq[15] = exq[15] + exq[i];
      repeat (3) @(posedge clk);
      second_pulse <= 1'b1;
      time_now <= stamp;
      @(posedge clk);
      time_now <= ~stamp; // stamp must already be held
      repeat (5) @(posedge clk);
      second_pulse <= 1'b0;
      repeat (50) @(posedge clk);
      second_pulse <= 1'b1; // edge while busy
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         while (rx_valid !== 1'b1) @(posedge clk);
         chk(rx_byte, exq[i]);
         chk({7'h0, rx_ok}, 8'h01);
      end
      repeat (8000) @(posedge clk);
      chk(8'(nrx), 8'd16);
      chk({6'h0, late_err, txd}, 8'h01);
      conclude();
   end
endmodule
